// file: hw/dtmc_pkg.sv
// Register map, fields, reset values, modes and timing of the dual timer.
// What this block does
// [RL1] Timer function counts every machine cycle
// [RL2] Counter samples pin, counts high-then-low
// [RL3] New count appears next machine cycle
// [RL4] Edge takes two machine cycles, four clocks
// [RL5] Source holds each level one machine cycle
// [RL6] Mode bit 2 picks timer 0 source
// [RL7] Two-bit mode fields per timer
// [RL8] Aux bit extends timer 0 mode, adds 6
// [RL9] Mode 3 differs between the timers
// [RL10] Optional pin toggle on timer 0 overflow
// [RL11] Non-counter parts write source bit zero
// [RL12] Three-bit timer 0 mode decode table
// [RL13] Run bit gates counting; rollover sets flag
// [RL14] Pin synchronised, two samples, falling flagged
package dtmc_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] TMC_IDX  = 8'h89;  // Mode control register.
  localparam logic [7:0] TAM_IDX  = 8'h8f;  // Auxiliary mode register.
  localparam logic [7:0] CTRL_IDX = 8'h90;  // Run bits and toggle option.
  localparam logic [7:0] CNT0_IDX = 8'h91;  // Timer 0 count.
  localparam logic [7:0] CNT1_IDX = 8'h92;  // Timer 1 count.
  localparam logic [7:0] STAT_IDX = 8'h93;  // Sticky event status, read only.
  localparam logic [7:0] CLR_IDX  = 8'h94;  // Status clear, write only.
  localparam logic [7:0] IEN_IDX  = 8'h95;  // Interrupt enable.

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int         TMC_T0SRC   = 2;      // Timer 0 source select bit.
  localparam int         TMC_T0M_LSB = 0;      // Timer 0 mode field, bits 1:0.
  localparam int         TMC_T1M_LSB = 4;      // Timer 1 mode field, bits 5:4.
  localparam logic [7:0] TMC_WMASK   = 8'h37;  // Writable bits; the rest read zero.
  localparam logic [7:0] TMC_RST     = 8'h00;
  localparam int         TAM_TIMER_ZERO_MODE_EXT    = 0;      // Third timer 0 mode bit.
  localparam logic [7:0] TAM_RST     = 8'h00;
  localparam int         CTRL_RUN0   = 0;      // Timer 0 run bit.
  localparam int         CTRL_RUN1   = 1;      // Timer 1 run bit.
  localparam int         CTRL_TOG0   = 2;      // Toggle pin on timer 0 overflow.
  localparam logic [2:0] CTRL_RST    = 3'h0;
  localparam int         ST_OVF0     = 0;      // Timer 0 overflow flag.
  localparam int         ST_OVF1     = 1;      // Timer 1 overflow flag.
  localparam int         ST_W        = 2;
  localparam logic [1:0] ST_RST      = 2'h0;
  localparam logic [15:0] CNT_RST    = 16'h0000;

  // ----------------------------------------------------------------
  // Timer 0 mode codes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    DTMC_M13    = 3'b000,  // 13-bit count with 5-bit prescale.
    DTMC_M16    = 3'b001,  // 16-bit cascade.
    DTMC_RELOAD = 3'b010,  // 8-bit auto-reload.
    DTMC_SPLIT  = 3'b011,  // Two 8-bit timers.
    DTMC_PWM    = 3'b110   // Pulse width mode.
  } dtmc_mode_t;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int         MC_CLKS = 2;  // CPU clocks per machine cycle.
  localparam int         EDGE_MC = 2;  // Machine cycles to recognise an edge.

endpackage

// file: hw/dtmc_timer.sv
// One timer/counter register pair with its count modes 0 to 3.
module dtmc_timer (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Count control
  input  wire logic        cnt_en,    // Advance low part (or whole count).
  input  wire logic        th_en,     // Advance high byte in split mode.
  input  wire logic [1:0]  mode,      // Mode 0 to 3.
  // Software access
  input  wire logic        wr_en,
  input  wire logic [15:0] wr_data,
  // State
  output logic      [15:0] count_q,
  output logic             ovf,       // Rollover of the main count, one cycle.
  output logic             th_ovf     // Rollover of the high byte in split mode.
);
  import dtmc_pkg::*;

  // ----------------------------------------------------------------
  // Next count
  // ----------------------------------------------------------------
  logic [15:0] count_d;  // Next count value.
  logic [12:0] c13;      // Thirteen-bit view used by mode 0.

  // Next count and rollover pulses.
  always_comb begin
    count_d = count_q;
    ovf     = 1'b0;
    th_ovf  = 1'b0;
    c13     = {count_q[15:8], count_q[4:0]};
    case (mode)
      // Mode 0: upper three bits of the low byte are left alone.
      2'd0: begin
        if (cnt_en) begin
          c13     = c13 + 13'h0001;
          count_d = {c13[12:5], count_q[7:5], c13[4:0]};
          // [RL13] rollover sets flag
          ovf     = (count_q[15:8] == 8'hff) && (count_q[4:0] == 5'h1f);
        end
      end
      // Mode 1: full sixteen bits.
      2'd1: begin
        if (cnt_en) begin
          count_d = count_q + 16'h0001;
          ovf     = (count_q == 16'hffff);
        end
      end
      // Mode 2: low byte reloads from the high byte.
      2'd2: begin
        if (cnt_en) begin
          if (count_q[7:0] == 8'hff) begin
            count_d[7:0] = count_q[15:8];
            ovf          = 1'b1;
          end else begin
            count_d[7:0] = count_q[7:0] + 8'h01;
          end
        end
      end
      // Mode 3: two bytes with separate enables.
      2'd3: begin
        if (cnt_en) begin
          count_d[7:0] = count_q[7:0] + 8'h01;
          ovf          = (count_q[7:0] == 8'hff);
        end
        if (th_en) begin
          count_d[15:8] = count_q[15:8] + 8'h01;
          th_ovf        = (count_q[15:8] == 8'hff);
        end
      end
      default: count_d = count_q;
    endcase
    // A software write wins.
    if (wr_en) begin
      count_d = wr_data;
    end
  end

  // Registers the count.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_q <= CNT_RST;
    end else begin
      count_q <= count_d;
    end
  end

endmodule

// file: hw/dtmc_top.sv
// Dual timer with mode control, counter input, pin toggle and AHB-Lite registers.
//
// Implementation choice: the AHB-Lite register port.
module dtmc_top #(
  parameter bit COUNTER_CAPABLE = 1'b1  // Timer 0 may count the external pin.
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  // Timer 0 event pin
  input  wire logic        timer_zero_event_pin_i,
  output logic             timer_zero_event_pin_o,
  output logic             timer_zero_event_pin_oe,
  // Interrupt
  output logic             irq
);
  import dtmc_pkg::*;

  // ----------------------------------------------------------------
  // Bus address phase capture
  // ----------------------------------------------------------------
  logic        wr_pend_q, wr_pend_d;   // A write data phase follows.
  logic [7:0]  wr_idx_q, wr_idx_d;     // Index of the pending write.
  logic [31:0] hrdata_q, hrdata_d;     // Read data, captured at address phase.
  logic        addr_ok;                // Address lies inside the index window.
  logic        take;                   // Valid transfer taken this edge.
  logic [7:0]  a_idx;                  // Index of the incoming address.

  // The slave never stalls and never errors.
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;

  assign take    = hsel && htrans[1] && hready;
  assign a_idx   = haddr[9:2];
  assign addr_ok = (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'b00) && (hsize == 3'b010);

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  logic [7:0]    tmc_q, tmc_d;    // Mode control.
  logic [7:0]    tam_q, tam_d;    // Auxiliary mode.
  logic [2:0]    ctrl_q, ctrl_d;  // Run bits and toggle option.
  logic [ST_W-1:0] stat_q, stat_d;  // Sticky overflow flags.
  logic [ST_W-1:0] ien_q, ien_d;    // Interrupt enables.
  logic          wr_go;           // Write data phase is now.
  logic [1:0]    cnt_wr;          // Per-timer count write strobes.
  logic [ST_W-1:0] ev_set;        // Events this cycle.

  assign wr_go     = wr_pend_q;
  assign cnt_wr[0] = wr_go && (wr_idx_q == CNT0_IDX);
  assign cnt_wr[1] = wr_go && (wr_idx_q == CNT1_IDX);

  // ----------------------------------------------------------------
  // Machine cycle and pin sampling
  // ----------------------------------------------------------------
  logic       mc_q, mc_d;             // Phase within the machine cycle.
  logic       tick;                   // One-cycle pulse per machine cycle.
  logic       pin_s1_q;               // Synchroniser first stage.
  logic       pin_s2_q;               // Synchroniser second stage.
  logic       samp_new_q, samp_new_d; // Newest machine-cycle sample.
  logic       edge_q, edge_d;         // Falling edge detected, count pending.

  // A machine cycle is MC_CLKS clocks; the tick lands on its last clock.
  assign tick = mc_q;

  // [RL14] pin two-flop synchroniser
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
    end else begin
      pin_s1_q <= timer_zero_event_pin_i;
      pin_s2_q <= pin_s1_q;
    end
  end

  // Computes the sampling state; the older sample is the held one.
  always_comb begin
    mc_d       = ~mc_q;
    samp_new_d = samp_new_q;
    edge_d     = edge_q;
    if (tick) begin
      // [RL2] sample once per cycle
      samp_new_d = pin_s2_q;
      // [RL14] older high, newer low
      // [RL4] two machine cycles recognise
      edge_d     = samp_new_q && !pin_s2_q;
    end
  end

  // Registers the sampling state. A level held under a machine cycle may
  // be missed; the source must hold each level longer.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mc_q       <= 1'b0;
      samp_new_q <= 1'b0;
      edge_q     <= 1'b0;
    end else begin
      mc_q       <= mc_d;
      samp_new_q <= samp_new_d;
      edge_q     <= edge_d;
    end
  end

  // ----------------------------------------------------------------
  // Mode decode and count enables
  // ----------------------------------------------------------------
  logic       t0_ext;      // Timer 0 counts the pin.
  dtmc_mode_t t0_mode;     // Full three-bit timer 0 mode.
  logic [1:0] t1_mode;     // Timer 1 mode.
  logic       t0_valid;    // Timer 0 mode is a defined one.
  logic [1:0] t0_core;     // Mode handed to the timer 0 core.
  logic       t0_step;     // Timer 0 source step.
  logic [1:0] cnt_en;      // Per-timer count enables.
  logic [1:0] th_en;       // Per-timer split high byte enables.
  logic [15:0] cnt_q [2];  // Counts of both timers.
  logic [1:0] ovf;         // Main rollovers.
  logic [1:0] th_ovf;      // Split high byte rollovers.
  logic [1:0] core_mode [2];

  // [RL6] source select bit
  // [RL11] ignored without counter capability
  assign t0_ext  = COUNTER_CAPABLE && tmc_q[TMC_T0SRC];
  // [RL7] two-bit mode fields
  // [RL8] aux bit extends timer 0
  assign t0_mode = dtmc_mode_t'({COUNTER_CAPABLE && tam_q[TAM_TIMER_ZERO_MODE_EXT],
                                 tmc_q[TMC_T0M_LSB+1:TMC_T0M_LSB]});
  assign t1_mode = tmc_q[TMC_T1M_LSB+1:TMC_T1M_LSB];

  // [RL12] three-bit mode decode
  always_comb begin
    t0_valid = 1'b1;
    case (t0_mode)
      DTMC_M13:    t0_core = 2'd0;
      DTMC_M16:    t0_core = 2'd1;
      DTMC_RELOAD: t0_core = 2'd2;
      DTMC_SPLIT:  t0_core = 2'd3;
      // Pulse width mode counts like auto-reload.
      DTMC_PWM:    t0_core = 2'd2;
      default: begin
        // Reserved codes freeze the timer.
        t0_core  = 2'd0;
        t0_valid = 1'b0;
      end
    endcase
  end

  // [RL1] clock step per tick
  // [RL3] pending edge counted next cycle
  assign t0_step = t0_ext ? edge_q : 1'b1;

  // [RL13] run bits gate counting
  // [RL9] timer 1 halts in mode 3
  assign cnt_en[0] = tick && ctrl_q[CTRL_RUN0] && t0_valid && t0_step;
  assign cnt_en[1] = tick && ctrl_q[CTRL_RUN1] && (t1_mode != 2'd3);
  // [RL9] split high on run1
  assign th_en[0]  = tick && ctrl_q[CTRL_RUN1] && (t0_mode == DTMC_SPLIT);
  assign th_en[1]  = 1'b0;

  assign core_mode[0] = t0_core;
  assign core_mode[1] = t1_mode;

  // Both timers share the same core; only the enables, modes and write strobes differ.
  for (genvar i = 0; i < 2; i++) begin : g_tmr
    dtmc_timer u_tmr (
      .hclk    (hclk),
      .hresetn (hresetn),
      .cnt_en  (cnt_en[i]),
      .th_en   (th_en[i]),
      .mode    (core_mode[i]),
      .wr_en   (cnt_wr[i]),
      .wr_data (hwdata[15:0]),
      .count_q (cnt_q[i]),
      .ovf     (ovf[i]),
      .th_ovf  (th_ovf[i])
    );
  end

  // [RL13] rollovers raise flags
  assign ev_set[ST_OVF0] = ovf[0];
  assign ev_set[ST_OVF1] = ovf[1] || th_ovf[0];

  // ----------------------------------------------------------------
  // Pin output: toggle and pulse width
  // ----------------------------------------------------------------
  logic tog_q, tog_d;  // Toggle level of the pin.
  logic pwm_q, pwm_d;  // Pulse width level of the pin.
  logic pwm_on;        // Pulse width mode active.

  assign pwm_on = (t0_mode == DTMC_PWM);

  // Computes pin levels. Pulse width output is high while the low byte is
  // below the high byte, so once the low byte has reloaded from the high byte the output stays low.
  always_comb begin
    tog_d = tog_q;
    // [RL10] toggle pin on overflow
    if (ovf[0] && ctrl_q[CTRL_TOG0]) begin
      tog_d = ~tog_q;
    end
    pwm_d = pwm_on && (cnt_q[0][7:0] < cnt_q[0][15:8]);
  end

  // Registers pin levels.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tog_q <= 1'b0;
      pwm_q <= 1'b0;
    end else begin
      tog_q <= tog_d;
      pwm_q <= pwm_d;
    end
  end

  // The pin is driven only in toggle or pulse width use. Counting it then
  // counts the block's own edges.
  assign timer_zero_event_pin_o  = pwm_on ? pwm_q : tog_q;
  assign timer_zero_event_pin_oe = pwm_on || ctrl_q[CTRL_TOG0];

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  // Bus phase, register writes, flags and read data.
  always_comb begin
    wr_pend_d = take && hwrite && addr_ok;
    wr_idx_d  = a_idx;
    hrdata_d  = hrdata_q;
    tmc_d     = tmc_q;
    tam_d     = tam_q;
    ctrl_d    = ctrl_q;
    ien_d     = ien_q;
    stat_d    = stat_q;
    // Data phase of a write.
    if (wr_go) begin
      case (wr_idx_q)
        TMC_IDX:  tmc_d  = hwdata[7:0] & TMC_WMASK;
        TAM_IDX:  tam_d  = {7'h00, hwdata[TAM_TIMER_ZERO_MODE_EXT]};
        CTRL_IDX: ctrl_d = hwdata[2:0];
        IEN_IDX:  ien_d  = hwdata[ST_W-1:0];
        CLR_IDX:  stat_d = stat_q & ~hwdata[ST_W-1:0];
        default:  ;
      endcase
    end
    // A new event wins over a clear in the same cycle.
    stat_d = stat_d | ev_set;
    // Read data is captured at the address phase; unmapped reads zero.
    if (take && !hwrite) begin
      hrdata_d = 32'h0000_0000;
      if (addr_ok) begin
        case (a_idx)
          TMC_IDX:  hrdata_d = {24'h0, tmc_q};
          TAM_IDX:  hrdata_d = {24'h0, tam_q};
          CTRL_IDX: hrdata_d = {29'h0, ctrl_q};
          CNT0_IDX: hrdata_d = {16'h0, cnt_q[0]};
          CNT1_IDX: hrdata_d = {16'h0, cnt_q[1]};
          STAT_IDX: hrdata_d = {30'h0, stat_q};
          IEN_IDX:  hrdata_d = {30'h0, ien_q};
          default:  hrdata_d = 32'h0000_0000;
        endcase
      end
    end
  end

  // Registers bus and software state.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_idx_q  <= 8'h00;
      hrdata_q  <= 32'h0000_0000;
      tmc_q     <= TMC_RST;
      tam_q     <= TAM_RST;
      ctrl_q    <= CTRL_RST;
      ien_q     <= ST_RST;
      stat_q    <= ST_RST;
    end else begin
      wr_pend_q <= wr_pend_d;
      wr_idx_q  <= wr_idx_d;
      hrdata_q  <= hrdata_d;
      tmc_q     <= tmc_d;
      tam_q     <= tam_d;
      ctrl_q    <= ctrl_d;
      ien_q     <= ien_d;
      stat_q    <= stat_d;
    end
  end

  // Level interrupt while any enabled flag is set.
  assign irq = |(stat_q & ien_q);

endmodule

// file: dv/dtmc_event_src.sv
// Model of the external event source on the timer 0 count pin.
module dtmc_event_src (
  // Clock
  input  wire logic hclk,
  // Pin level
  output logic      lvl
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Falling edge generator
  // ----------------------------------------------------------------
  // The line idles high, as a pulled-up pin does.
  initial lvl = 1'b1;
  // level held hold clocks; two clocks is one machine cycle
  // Two clocks a level is the fastest legal rate; more is a slow source.
  task automatic falls(input int n, input int hold);
    repeat (n) begin
      repeat (hold) @(posedge hclk);
      lvl <= 1'b0;
      repeat (hold) @(posedge hclk);
      lvl <= 1'b1;
    end
  endtask
endmodule

// file: dv/dtmc_checker.sv
// Checker bound to the dual timer top.
module dtmc_checker
  import dtmc_pkg::*;
#(
  parameter bit COUNTER_CAPABLE = 1'b1  // Aux mode bit only counts when set.
) (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // Pin and interrupt
  input wire logic        timer_zero_event_pin_i,
  input wire logic        timer_zero_event_pin_o,
  input wire logic        timer_zero_event_pin_oe,
  input wire logic        irq
);
  // ----------------------------------------------------------------
  // Shadow of the control registers
  // ----------------------------------------------------------------
  logic       ta, tk, unm, pwm;             // Taken, word taken, unmapped, pwm mode.
  logic       wr_q, wr_d;                   // Write data phase pending.
  logic [7:0] wi_q, wi_d;                   // Index of that write.
  logic [7:0] md_q, md_d, ax_q, ax_d;       // Mode and aux shadows.
  logic [7:0] ct_q, ct_d, ie_q, ie_d;       // Control and enable shadows.
  // Next shadow values; a write lands at the end of its data phase.
  always_comb begin
    ta   = hsel && htrans[1] && hready;
    tk   = ta && hsize == 3'b010;
    unm  = !(haddr[9:2] == TMC_IDX || haddr[9:2] == TAM_IDX
           || (haddr[9:2] >= CTRL_IDX && haddr[9:2] <= IEN_IDX))
           || haddr[31:10] != 22'h0 || haddr[1:0] != 2'b00 || hsize != 3'b010;
    pwm  = COUNTER_CAPABLE && {ax_q[0], md_q[1:0]} == 3'b110;
    wr_d = tk && hwrite;
    wi_d = haddr[9:2];
    md_d = md_q;
    ax_d = ax_q;
    ct_d = ct_q;
    ie_d = ie_q;
    if (wr_q) begin
      case (wi_q)
        TMC_IDX:  md_d = hwdata[7:0] & TMC_WMASK;
        TAM_IDX:  ax_d = {7'h0, hwdata[0]};
        CTRL_IDX: ct_d = {5'h0, hwdata[2:0]};
        IEN_IDX:  ie_d = {6'h0, hwdata[1:0]};
        default:       ;
      endcase
    end
  end
  // Shadow registers, cleared like the design's.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {wr_q, wi_q, md_q, ax_q, ct_q, ie_q} <= '0;
    end else begin
      {wr_q, wi_q, md_q, ax_q, ct_q, ie_q} <= {wr_d, wi_d, md_d, ax_d, ct_d, ie_d};
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_ready; hreadyout; endproperty
  property p_okay; !hresp; endproperty
  property p_rdata_hold; !$past(ta && !hwrite) |-> $stable(hrdata); endproperty
  property p_unmapped; ta && !hwrite && unm |=> hrdata == 32'h0; endproperty
  property p_mode_read;
    tk && !hwrite && haddr[9:2] == TMC_IDX && haddr[31:10] == 22'h0
      |=> hrdata == {24'h0, $past(md_q)};
  endproperty
  property p_ien_off;
    tk && hwrite && haddr[9:2] == IEN_IDX ##1 hwdata[1:0] == 2'b00 |-> ##1 !irq;
  endproperty
  property p_oe; timer_zero_event_pin_oe == (ct_q[CTRL_TOG0] || pwm); endproperty
  property p_pin_hold;
    (ct_q[CTRL_TOG0] && !ct_q[CTRL_RUN0] && !pwm) [*4] |-> $stable(timer_zero_event_pin_o);
  endproperty
  property p_irq_ien; irq |-> ie_q[1:0] != 2'b00; endproperty
  a_ready: assert property (p_ready) else $error("hreadyout low");
  a_okay: assert property (p_okay) else $error("error response");
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_mode_read: assert property (p_mode_read) else $error("mode readback wrong");
  a_ien_off: assert property (p_ien_off) else $error("irq with enable clear");
  a_oe: assert property (p_oe) else $error("pin enable wrong");
  a_pin_hold: assert property (p_pin_hold) else $error("pin moved while stopped");
  a_irq_ien: assert property (p_irq_ien) else $error("irq without enable");
  c_irq: cover property ($rose(irq));
  c_oe: cover property ($rose(timer_zero_event_pin_oe));
  c_tog: cover property (timer_zero_event_pin_oe && $changed(timer_zero_event_pin_o));
endmodule
bind dtmc_top dtmc_checker #(.COUNTER_CAPABLE(COUNTER_CAPABLE)) dtmc_checker_inst (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq),
  .timer_zero_event_pin_i(timer_zero_event_pin_i),
  .timer_zero_event_pin_o(timer_zero_event_pin_o),
  .timer_zero_event_pin_oe(timer_zero_event_pin_oe));

// file: dv/tb_top.sv
// Self-checking bench for the dual timer block.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import dtmc_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, v, a;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        pin_i, pin_o, pin_oe, irq, lvl, p;
  logic [75:0] r;                   // One row of the mode table.
  int          err_total, checks;
  // Mode table: aux, mode, index, run, start, expected, mask, status.
  localparam logic [75:0] TBL[8] = '{76'h0_00_91_1_ff1f_0000_ff1f_1,
    76'h0_01_91_1_00ff_0100_ffff_0, 76'h0_02_91_1_80ff_8080_ffff_1,
    76'h0_03_91_3_10ff_1100_ffff_1, 76'h1_00_91_1_1234_1234_ffff_0,
    76'h1_02_91_1_80ff_8080_ffff_1, 76'h0_30_92_2_00ff_00ff_ffff_0,
    76'h0_10_92_2_00ff_0100_ffff_0};
  // The pin shows the block's drive while enabled, else the source.
  assign pin_i = pin_oe ? pin_o : lvl;
  dtmc_top dtmc_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq),
    .timer_zero_event_pin_i(pin_i), .timer_zero_event_pin_o(pin_o),
    .timer_zero_event_pin_oe(pin_oe));
  dtmc_event_src dtmc_event_src_inst (.hclk(hclk), .lvl(lvl));
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Waits for hready at a rising edge; a stuck bus ends the run.
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        err_total++;
        conclude();
      end
      @(posedge hclk);
    end
  endtask
  // One single word transfer; entered just after a rising edge.
  task automatic xfer(input logic w, input logic [31:0] ad, input logic [31:0] wd,
                      output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= ad;
    hwrite <= w;
    htrans <= 2'b10;
    hsize  <= 3'b010;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] ix, input logic [31:0] d);
    logic [31:0] t;
    xfer(1'b1, {22'h0, ix, 2'b00}, d, t);
  endtask
  task automatic rchk(input logic [7:0] ix, input logic [31:0] e, input logic [31:0] m);
    logic [31:0] t;
    xfer(1'b0, {22'h0, ix, 2'b00}, 32'h0, t);
    cmp(t & m, e);
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {hresetn, hsel, hwrite, htrans, hsize, haddr, hwdata, err_total, checks} = '0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (TBL[i]) rchk(8'h89 + 8'(i == 0 ? 0 : i + 6), 0, '1);
    rchk(TAM_IDX, 0, '1);
    xfer(1'b0, 32'h0000_0400, 0, v);
    cmp(v, 0);
    wr(TMC_IDX, 'hff);
    rchk(TMC_IDX, 'h37, '1);
    wr(STAT_IDX, 3);
    rchk(STAT_IDX, 0, '1);
    $display("test registers done");
    // Free running count: 22 clocks between samples are 11 ticks.
    wr(TMC_IDX, 1);
    wr(CNT0_IDX, 0);
    for (int run = 1; run >= 0; run--) begin
      wr(CTRL_IDX, 32'(run));
      xfer(1'b0, {22'h0, CNT0_IDX, 2'b00}, 32'h0, a);
      repeat (20) @(posedge hclk);
      xfer(1'b0, {22'h0, CNT0_IDX, 2'b00}, 32'h0, v);
      cmp(v - a, 32'(run * 11));
    end
    $display("test timer done");
    // Overflow sets status; irq masked, then raised, then cleared.
    wr(CNT0_IDX, 'hfffe);
    wr(CTRL_IDX, 1);
    repeat (10) @(posedge hclk);
    cmp(32'(irq), 0);
    rchk(STAT_IDX, 1, 1);
    wr(IEN_IDX, 1);
    @(posedge hclk);
    cmp(32'(irq), 1);
    wr(CTRL_IDX, 0);
    wr(CLR_IDX, 3);
    rchk(STAT_IDX, 0, 1);
    cmp(32'(irq), 0);
    wr(IEN_IDX, 0);
    $display("test interrupt done");
    // Pin events count only in counter function while running.
    wr(CNT0_IDX, 0);
    wr(TMC_IDX, 5);
    wr(CTRL_IDX, 1);
    dtmc_event_src_inst.falls(5, 2);
    repeat (12) @(posedge hclk);
    rchk(CNT0_IDX, 5, 'hffff);
    dtmc_event_src_inst.falls(3, 5);
    repeat (12) @(posedge hclk);
    rchk(CNT0_IDX, 8, 'hffff);
    wr(CTRL_IDX, 0);
    dtmc_event_src_inst.falls(2, 2);
    repeat (12) @(posedge hclk);
    rchk(CNT0_IDX, 8, 'hffff);
    $display("test counter done");
    // Each mode table row runs for exactly one tick.
    foreach (TBL[i]) begin
      r = TBL[i];
      wr(CLR_IDX, 32'h3);
      wr(TAM_IDX, {28'h0, r[75:72]});
      wr(TMC_IDX, {24'h0, r[71:64]});
      wr(r[63:56], {16'h0, r[51:36]});
      wr(CTRL_IDX, {28'h0, r[55:52]});
      wr(CTRL_IDX, 32'h0);
      rchk(r[63:56], {16'h0, r[35:20]}, {16'h0, r[19:4]});
      rchk(STAT_IDX, {28'h0, r[3:0]}, 3);
    end
    wr(TAM_IDX, 0);
    $display("test modes done");
    // Pin flips when timer 0 overflows with toggling on.
    wr(TMC_IDX, 1);
    wr(CNT0_IDX, 'hfffe);
    wr(CTRL_IDX, 5);
    @(posedge hclk);
    cmp(32'(pin_oe), 1);
    p = pin_o;
    for (int n = 0; n < 20 && pin_o === p; n++) @(posedge hclk);
    cmp(32'(pin_o), {31'h0, ~p});
    wr(CTRL_IDX, 4);
    p = pin_o;
    repeat (6) @(posedge hclk);
    cmp(32'(pin_o), 32'(p));
    wr(CTRL_IDX, 0);
    @(posedge hclk);
    cmp(32'(pin_oe), 0);
    $display("test toggle done");
    conclude();
  end
endmodule
